// ---- hdl/phy_link_datapath.sv ----
// PHY-link datapath: link clock, parallel lanes, cable port modes and repeating
// Notes on behaviour
// - Legacy link mode drives a 49.152 MHz clock to the link controller.
// - Newer link mode drives a 98.304 MHz clock to the link controller.
// - Legacy lanes carry 2/4/8 bits per clock; newer lanes carry 8 bits.
// - Outbound link chunks are latched, packed into bytes, then encoded for the cable.
// - Cable rates are S100, S200, S400, S400B or S800.
// - Select held low for a legacy link; interface runs the legacy protocol.
// - Select held high for a newer link; interface runs the newer protocol.
// - Select never picks cable mode; low select disables owner-supervisor arbitration.
// - Ports facing legacy devices use data-strobe signalling at S100, S200 or S400.
// - Bilingual ports facing newer nodes use newer signalling at S400B or S800.
// - Each bilingual port picks its signalling from the attached port's capability.
// - A port forced to legacy never uses newer signalling.
// - Received bytes split into 2/4/8 bit chunks on the local link clock.
// - Received data is repeated on every other connected, active port.
// - Power-down input high stops the PLL and the link clock.
`timescale 1ns/1ps
`default_nettype none
`include "phy_link_consts.svh"
module phy_link_datapath #(
    parameter int PORTS  = 3,
    parameter int LINK_W = 8
) (
    // Clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          rst,
    // Straps and power
    input  wire logic                          link_protocol_select,
    input  wire logic                          pll_power_down_input,
    // Link transmit lanes
    input  wire logic [LINK_W-1:0]             link_tx_data,
    input  wire logic                          link_tx_valid,
    input  wire phy_link_pkg::speed_type       link_tx_speed,
    // Link clock and receive lanes
    output logic                               link_clk_out,
    output logic [LINK_W-1:0]                  link_rx_data,
    output logic                               link_rx_valid,
    output logic                               link_rx_overrun,
    // Port configuration and status
    input  wire logic [PORTS-1:0]              port_connected,
    input  wire logic [PORTS-1:0]              port_active,
    input  wire logic [PORTS-1:0]              port_force_legacy,
    input  wire logic [PORTS-1:0]              port_peer_bilingual,
    // Cable receive bytes
    input  wire logic [PORTS*LINK_W-1:0]       cable_rx_byte,
    input  wire logic [PORTS-1:0]              cable_rx_valid,
    input  wire logic [PORTS*3-1:0]            cable_rx_speed,
    // Cable transmit bytes
    output logic [PORTS*LINK_W-1:0]            cable_tx_byte,
    output logic [PORTS-1:0]                   cable_tx_valid,
    output logic [PORTS*3-1:0]                 cable_tx_speed,
    output logic [PORTS-1:0]                   port_bilingual_mode,
    // Node status
    output logic                               owner_supervisor_arbitration,
    output logic                               pll_running
);
    import phy_link_pkg::*;

    typedef struct packed {
        link_state_type            lstate;
        logic [31:0]               phase;
        logic                      clk;
        logic                      tick;
        logic                      osa_en;
        logic [PORTS-1:0]          bilingual;
        logic [15:0]               scram;
        logic [PORTS*LINK_W-1:0]   tx_byte;
        logic [PORTS-1:0]          tx_valid;
        logic [PORTS*3-1:0]        tx_speed;
        logic [LINK_W-1:0]         rx_byte;
        logic                      rx_load;
        logic [3:0]                rx_width;
    } datapath_state_type;

    datapath_state_type st_reg;
    datapath_state_type st_next;

    logic [32:0]       phase_sum;
    logic [31:0]       phase_step;
    logic [PORTS-1:0]  live;
    logic [PORTS-1:0]  repeat_mask;
    logic              rx_found;
    logic [LINK_W-1:0] rx_pick;
    speed_type         rx_speed;
    logic [LINK_W-1:0] packed_byte;
    logic              packed_valid;
    logic              scram_used;

    // Lane width follows requested speed only in legacy link mode
    function automatic logic [3:0] lane_width(speed_type spd, logic newer);
        if (newer) begin
            return `WIDTH_NEWER;
        end

        case (spd)
            SPD_S100: return `WIDTH_S100;
            SPD_S200: return `WIDTH_S200;
            default:  return `WIDTH_S400;
        endcase
    endfunction

    // Clamp a speed to what the port's signalling can carry
    function automatic speed_type port_speed(speed_type spd, logic bilingual);
        if (bilingual) begin
            return (spd == SPD_S800) ? SPD_S800 : SPD_S400B;
        end
        return (spd > SPD_S400) ? SPD_S400 : spd;
    endfunction

    // Eight steps of the cable scrambler per byte
    function automatic logic [15:0] scram_advance(logic [15:0] s);
        logic [15:0] v;

        v = s;

        for (int i = 0; i < 8; i++) begin
            v = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
        end
        return v;
    endfunction

    lane_packer #(
        .LINK_W      (LINK_W)
    ) u_packer (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .tick        (st_reg.tick),
        .chunk_valid (link_tx_valid),
        .chunk       (link_tx_data),
        .chunk_width (lane_width(link_tx_speed, st_reg.osa_en)),
        .byte_out    (packed_byte),
        .byte_valid  (packed_valid)
    );

    lane_splitter #(
        .LINK_W      (LINK_W)
    ) u_splitter (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .byte_load   (st_reg.rx_load),
        .byte_in     (st_reg.rx_byte),
        .byte_width  (st_reg.rx_width),
        .tick        (st_reg.tick),
        .chunk_out   (link_rx_data),
        .chunk_valid (link_rx_valid),
        .overrun     (link_rx_overrun)
    );

    always_comb begin
        st_next = st_reg;

        // Carry is the tick, msb the link clock
        phase_step = link_protocol_select ? `NCO_STEP(`NEWER_LINK_KHZ)
                                          : `NCO_STEP(`LEGACY_LINK_KHZ);
        phase_sum = {1'b0, st_reg.phase} + {1'b0, phase_step};

        live = port_connected & port_active;

        rx_found = 1'b0;
        rx_pick = '0;
        rx_speed = SPD_S100;
        repeat_mask = '0;
        scram_used = 1'b0;

        if (pll_power_down_input) begin
            // Link clock stands low while the PLL is stopped
            st_next.lstate = LINK_HALTED;
            st_next.phase = `NCO_RESET;
            st_next.clk = 1'b0;
            st_next.tick = 1'b0;
        end else begin
            st_next.lstate = LINK_RUNNING;
            st_next.phase = phase_sum[31:0];
            st_next.clk = phase_sum[31];
            st_next.tick = phase_sum[32];
        end

        st_next.osa_en = link_protocol_select;

        st_next.bilingual = ~port_force_legacy & port_peer_bilingual & port_connected;

        // Lowest-numbered receiving port wins; a healthy bus has only one
        for (int p = PORTS - 1; p >= 0; p--) begin
            if (cable_rx_valid[p] && live[p]) begin
                rx_found = 1'b1;
                rx_pick = cable_rx_byte[p*LINK_W +: LINK_W];
                rx_speed = speed_type'(cable_rx_speed[p*3 +: 3]);
                repeat_mask = live & ~(PORTS'(1) << p);
            end
        end

        st_next.rx_load = rx_found;
        st_next.rx_byte = rx_pick;
        st_next.rx_width = lane_width(rx_speed, link_protocol_select);

        // Repeating outranks local sends; a node does not talk while receiving
        st_next.tx_valid = '0;

        for (int p = 0; p < PORTS; p++) begin
            if (rx_found && repeat_mask[p]) begin
                st_next.tx_valid[p] = 1'b1;
                st_next.tx_speed[p*3 +: 3] = port_speed(rx_speed, st_next.bilingual[p]);
                st_next.tx_byte[p*LINK_W +: LINK_W] = st_next.bilingual[p]
                    ? rx_pick ^ st_reg.scram[LINK_W-1:0] : rx_pick;
                scram_used = scram_used | st_next.bilingual[p];
            end else if (!rx_found && packed_valid && live[p]) begin
                st_next.tx_valid[p] = 1'b1;
                st_next.tx_speed[p*3 +: 3] = port_speed(link_tx_speed, st_next.bilingual[p]);
                st_next.tx_byte[p*LINK_W +: LINK_W] = st_next.bilingual[p]
                    ? packed_byte ^ st_reg.scram[LINK_W-1:0] : packed_byte;
                scram_used = scram_used | st_next.bilingual[p];
            end
        end
        if (scram_used) begin
            st_next.scram = scram_advance(st_reg.scram);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.lstate <= LINK_HALTED;
            st_reg.scram <= `SCRAMBLE_RESET;
            st_reg.tx_speed <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign link_clk_out = st_reg.clk;

    assign cable_tx_byte = st_reg.tx_byte;
    assign cable_tx_valid = st_reg.tx_valid;
    assign cable_tx_speed = st_reg.tx_speed;
    assign port_bilingual_mode = st_reg.bilingual;

    assign owner_supervisor_arbitration = st_reg.osa_en;
    assign pll_running = (st_reg.lstate == LINK_RUNNING);

    default clocking cb_sys @(posedge sys_clk);
    endclocking

    default disable iff (rst);

    sequence s_legacy_gap;
        !st_reg.tick [*3] ##[1:2] st_reg.tick;
    endsequence

    sequence s_newer_gap;
        !st_reg.tick ##[1:2] st_reg.tick;
    endsequence

    a_pll_stop_clock: assert property (
        pll_power_down_input |=> (!link_clk_out && !pll_running && !st_reg.tick))
        else $error("link clock runs while powered down");

    a_pll_resume: assert property (
        !pll_power_down_input |=> pll_running)
        else $error("link clock not restarted after power-down");

    a_legacy_clk_rate: assert property (
        disable iff (rst || pll_power_down_input)
        (st_reg.tick && !link_protocol_select && !pll_power_down_input)
        |=> ((!link_protocol_select && !pll_power_down_input) throughout s_legacy_gap))
        else $error("legacy link clock period wrong");

    a_newer_clk_rate: assert property (
        disable iff (rst || pll_power_down_input)
        (st_reg.tick && link_protocol_select && !pll_power_down_input)
        |=> ((link_protocol_select && !pll_power_down_input) throughout s_newer_gap))
        else $error("newer link clock period wrong");

    a_osa_disabled: assert property (
        !link_protocol_select [*2] |-> !owner_supervisor_arbitration)
        else $error("owner-supervisor arbitration enabled in legacy mode");

    for (genvar p = 0; p < PORTS; p++) begin : g_port_chk

        a_legacy_port_speed: assert property (
            (cable_tx_valid[p] && !port_bilingual_mode[p])
            |-> (speed_type'(cable_tx_speed[p*3 +: 3]) <= SPD_S400))
            else $error("legacy port sent at a newer speed");

        a_newer_port_speed: assert property (
            (cable_tx_valid[p] && port_bilingual_mode[p])
            |-> (speed_type'(cable_tx_speed[p*3 +: 3]) >= SPD_S400B))
            else $error("bilingual port sent at a legacy speed");

        a_forced_legacy: assert property (
            $past(port_force_legacy[p]) |-> !port_bilingual_mode[p])
            else $error("forced legacy port in newer signalling");

        a_repeat_other: assert property (
            (cable_rx_valid[p] && live[p] && $onehot(cable_rx_valid & live))
            |=> (cable_tx_valid == ($past(live) & ~(PORTS'(1) << p))))
            else $error("received byte not repeated on the other ports");
    end
endmodule
`default_nettype wire

// ---- hdl/phy_link_consts.svh ----
// Constants of the PHY-link datapath: clock rates, lane widths and reset values
`ifndef PHY_LINK_CONSTS_SVH
`define PHY_LINK_CONSTS_SVH

// Rates in kHz
`define SYS_CLK_KHZ      64'd200000
`define LEGACY_LINK_KHZ  64'd49152
`define NEWER_LINK_KHZ   64'd98304

// Phase step per sys_clk; truncation makes the link clock run a hair slow, never fast
`define NCO_STEP(khz)    32'((64'(khz) << 32) / `SYS_CLK_KHZ)

// Serial rates in kbit/s, for reference by speed code
`define S100_KBPS        98304
`define S200_KBPS        196608
`define S400_KBPS        393216
`define S400B_KBPS       491520
`define S800_KBPS        983040

// Lane widths on the parallel link data lines
`define WIDTH_S100       4'h2
`define WIDTH_S200       4'h4
`define WIDTH_S400       4'h8
`define WIDTH_NEWER      4'h8

// Reset values
`define NCO_RESET        32'h0
`define SCRAMBLE_RESET   16'hffff

`endif

// ---- hdl/phy_link_pkg.sv ----
// Types shared by the PHY-link datapath modules
`default_nettype none
package phy_link_pkg;
    typedef enum logic [2:0] {SPD_S100, SPD_S200, SPD_S400, SPD_S400B, SPD_S800} speed_type;
    typedef enum logic {LINK_HALTED, LINK_RUNNING} link_state_type;
endpackage
`default_nettype wire

// ---- hdl/lane_packer.sv ----
// Packs 2, 4 or 8 bit link chunks, MSB first, into whole bytes
`timescale 1ns/1ps
`default_nettype none
module lane_packer #(
    parameter int LINK_W = 8
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // Link side, sampled on link clock ticks
    input  wire logic              tick,
    input  wire logic              chunk_valid,
    input  wire logic [LINK_W-1:0] chunk,
    input  wire logic [3:0]        chunk_width,
    // Packed byte, one-cycle pulse
    output logic [LINK_W-1:0]      byte_out,
    output logic                   byte_valid
);
    import phy_link_pkg::*;

    typedef struct packed {
        logic [LINK_W-1:0] shift;
        logic [3:0]        fill;
        logic [LINK_W-1:0] out;
        logic              valid;
    } packer_state_type;

    packer_state_type  st_reg;
    packer_state_type  st_next;
    logic [LINK_W:0]   mask_wide;
    logic [LINK_W-1:0] merged;

    always_comb begin
        st_next = st_reg;
        st_next.valid = 1'b0;
        mask_wide = ((LINK_W+1)'(1) << chunk_width) - (LINK_W+1)'(1);
        merged = (st_reg.shift << chunk_width) | (chunk & mask_wide[LINK_W-1:0]);
        if (tick && chunk_valid) begin
            if (st_reg.fill + chunk_width >= 4'(LINK_W)) begin
                st_next.out = merged;
                st_next.valid = 1'b1;
                st_next.fill = 4'h0;
            end else begin
                st_next.shift = merged;
                st_next.fill = st_reg.fill + chunk_width;
            end
        end else if (tick) begin
            // A packet ending mid-byte leaves a fragment that is dropped
            st_next.fill = 4'h0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign byte_out = st_reg.out;
    assign byte_valid = st_reg.valid;

    a_pack_full_width: assert property (@(posedge sys_clk) disable iff (rst)
        (tick && chunk_valid && chunk_width == 4'(LINK_W) && st_reg.fill == 4'h0)
        |=> (byte_valid && byte_out == $past(chunk)))
        else $error("full-width chunk not passed as a byte");
endmodule
`default_nettype wire

// ---- hdl/lane_splitter.sv ----
// Splits received bytes into 2, 4 or 8 bit chunks, one per link clock tick
`timescale 1ns/1ps
`default_nettype none
module lane_splitter #(
    parameter int LINK_W = 8
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // Byte side
    input  wire logic              byte_load,
    input  wire logic [LINK_W-1:0] byte_in,
    input  wire logic [3:0]        byte_width,
    // Link side
    input  wire logic              tick,
    output logic [LINK_W-1:0]      chunk_out,
    output logic                   chunk_valid,
    output logic                   overrun
);
    import phy_link_pkg::*;

    typedef struct packed {
        logic [LINK_W-1:0] shift;
        logic [3:0]        left;
        logic [3:0]        width;
        logic [LINK_W-1:0] pend;
        logic [3:0]        pend_width;
        logic              pend_valid;
        logic [LINK_W-1:0] out;
        logic              valid;
        logic              overrun;
    } splitter_state_type;

    splitter_state_type st_reg;
    splitter_state_type st_next;

    always_comb begin
        st_next = st_reg;
        st_next.valid = 1'b0;
        if (tick && st_reg.left != 4'h0) begin
            st_next.out = st_reg.shift >> (4'(LINK_W) - st_reg.width);
            st_next.shift = st_reg.shift << st_reg.width;
            st_next.left = st_reg.left - st_reg.width;
            st_next.valid = 1'b1;
        end
        if (st_next.left == 4'h0 && st_reg.pend_valid) begin
            st_next.shift = st_reg.pend;
            st_next.width = st_reg.pend_width;
            st_next.left = 4'(LINK_W);
            st_next.pend_valid = 1'b0;
        end
        if (byte_load) begin
            // One byte of slack; a faster cable than link loses the newest byte
            if (st_next.pend_valid) begin
                st_next.overrun = 1'b1;
            end else begin
                st_next.pend = byte_in;
                st_next.pend_width = byte_width;
                st_next.pend_valid = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign chunk_out = st_reg.out;
    assign chunk_valid = st_reg.valid;
    assign overrun = st_reg.overrun;

    a_chunk_on_tick: assert property (@(posedge sys_clk) disable iff (rst)
        chunk_valid |-> $past(tick))
        else $error("chunk issued outside a link clock tick");
endmodule
`default_nettype wire

// ---- dv/link_ctrl_model.sv ----
// Behavioural link controller driving the transmit lanes
`timescale 1ns/1ps
`default_nettype none
module link_ctrl_model (
    // Clocks
    input  wire logic       sys_clk,
    input  wire logic       link_clk_out,
    // Bench side
    input  wire logic [3:0] chunk_w,
    input  wire logic       push,
    input  wire logic [7:0] push_byte,
    output logic            idle,
    // Transmit lanes
    output logic [7:0]      link_tx_data,
    output logic            link_tx_valid
);
    logic [7:0] q[$];
    logic [7:0] cur;
    logic       clk_d;
    int         left;
    initial begin
        link_tx_data = 8'h00;
        link_tx_valid = 1'b0;
        idle = 1'b1;
        clk_d = 1'b0;
        left = 0;
    end
    always @(posedge sys_clk) begin
        if (push) q.push_back(push_byte);
    end
    // Change just after the link clock falls, so lanes stand still across the tick
    always @(negedge sys_clk) begin
        clk_d <= link_clk_out;
        if (clk_d && !link_clk_out) begin
            if (left == 0 && q.size() > 0) begin
                cur = q.pop_front();
                left = 8 / chunk_w;
            end
            if (left > 0) begin
                link_tx_data <= cur >> (8 - chunk_w);
                cur = cur << chunk_w;
                left = left - 1;
                link_tx_valid <= 1'b1;
            end else begin
                // Idle lanes toggle so stale data is never mistaken for a chunk
                link_tx_valid <= 1'b0;
                link_tx_data <= ~link_tx_data;
            end
        end
        idle <= (q.size() == 0) && (left == 0);
    end
endmodule
`default_nettype wire

// ---- dv/test_phy_link_datapath.sv ----
// Self-checking bench for the PHY-link datapath
`timescale 1ns/1ps
`default_nettype none
module test_phy_link_datapath;
    import phy_link_pkg::*;
    typedef struct {
        logic [2:0] vld;
        logic [2:0] cmp;
        logic [7:0] byt;
        logic [8:0] spd;
    } note_type;
    logic        sys_clk, rst, link_protocol_select, pll_power_down_input;
    logic [7:0]  link_tx_data, link_rx_data, push_byte;
    logic        link_tx_valid, link_clk_out, link_rx_valid, link_rx_overrun;
    speed_type   link_tx_speed;
    logic [2:0]  port_connected, port_active, port_force_legacy, port_peer_bilingual;
    logic [23:0] cable_rx_byte, cable_tx_byte;
    logic [2:0]  cable_rx_valid, cable_tx_valid, port_bilingual_mode;
    logic [8:0]  cable_rx_speed, cable_tx_speed;
    logic        owner_supervisor_arbitration, pll_running, push, idle;
    logic [3:0]  chunk_w;
    logic [31:0] seed;
    note_type    txq[$];
    note_type    nt;
    logic [15:0] rxq[$];
    logic [15:0] rn;
    int          mismatches, tests_run, cycles;

    phy_link_datapath uut (.sys_clk, .rst, .link_protocol_select, .pll_power_down_input,
        .link_tx_data, .link_tx_valid, .link_tx_speed, .link_clk_out, .link_rx_data,
        .link_rx_valid, .link_rx_overrun, .port_connected, .port_active, .port_force_legacy,
        .port_peer_bilingual, .cable_rx_byte, .cable_rx_valid, .cable_rx_speed,
        .cable_tx_byte, .cable_tx_valid, .cable_tx_speed, .port_bilingual_mode,
        .owner_supervisor_arbitration, .pll_running);
    link_ctrl_model link_model (.sys_clk, .link_clk_out, .chunk_w, .push, .push_byte,
        .idle, .link_tx_data, .link_tx_valid);

    always #2.5 sys_clk = ~sys_clk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [2:0] clamp(input speed_type s, input logic bil);
        if (bil) return (s == SPD_S800) ? SPD_S800 : SPD_S400B;
        return (s > SPD_S400) ? SPD_S400 : s;
    endfunction
    function automatic logic [3:0] width(input speed_type s);
        if (link_protocol_select || s >= SPD_S400) return 4'h8;
        return (s == SPD_S100) ? 4'h2 : 4'h4;
    endfunction
    task automatic check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic test_done(input string s);
        $display("Test %s done, %0d mismatches so far", s, mismatches);
    endtask
    task automatic end_of_test();
        $display("Counts: %0d checks, %0d mismatches", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Result monitor: oldest note against each output pulse
    always @(negedge sys_clk) begin
        if (!rst && cable_tx_valid !== 3'b000) begin
            if (txq.size() == 0) check(1'b0, "unexpected cable byte");
            else begin
                nt = txq.pop_front();
                check(cable_tx_valid === nt.vld, "cable valid mask");
                for (int p = 0; p < 3; p++) begin
                    if (nt.vld[p]) begin
                        check(cable_tx_speed[3*p+:3] === nt.spd[3*p+:3], "cable speed");
                        if (nt.cmp[p]) check(cable_tx_byte[8*p+:8] === nt.byt, "cable byte");
                    end
                end
            end
        end
        if (!rst && link_rx_valid !== 1'b0) begin
            if (rxq.size() == 0) check(1'b0, "unexpected rx chunk");
            else begin
                rn = rxq.pop_front();
                check((link_rx_data & rn[15:8]) === rn[7:0], "rx chunk");
            end
        end
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic wait_empty();
        int k;
        k = 0;
        while ((txq.size() + rxq.size() != 0 || !idle) && k < 400) begin
            @(negedge sys_clk);
            k++;
        end
        check(k < 400, "results missing");
        repeat (6) @(negedge sys_clk);
    endtask
    task automatic rst_mode(input logic s);
        @(negedge sys_clk);
        rst = 1'b1;
        link_protocol_select = s;
        repeat (3) @(negedge sys_clk);
        check(pll_running === 1'b0 && link_clk_out === 1'b0 && cable_tx_valid === 3'b000
              && link_rx_overrun === 1'b0, "reset outputs");
        rst = 1'b0;
        repeat (2) @(negedge sys_clk);
        check(owner_supervisor_arbitration === s, "arbitration enable");
        check(pll_running === 1'b1, "pll after reset");
    endtask
    task automatic clk_rate(input int khz);
        int n;
        logic prev;
        n = 0;
        prev = link_clk_out;
        repeat (1000) begin
            @(negedge sys_clk);
            if (prev === 1'b0 && link_clk_out === 1'b1) n++;
            prev = link_clk_out;
        end
        check(n >= khz / 200 && n <= khz / 200 + 1, "link clock rate");
    endtask
    task automatic ports(input logic [2:0] c, a, f, b);
        @(negedge sys_clk);
        port_connected = c;
        port_active = a;
        port_force_legacy = f;
        port_peer_bilingual = b;
        repeat (2) @(negedge sys_clk);
        check(port_bilingual_mode === (~f & b & c), "port mode");
    endtask
    task automatic tx_bytes(input speed_type s, input int n);
        note_type t;
        link_tx_speed = s;
        chunk_w = width(s);
        repeat (n) begin
            @(negedge sys_clk);
            push = 1'b1;
            push_byte = 8'(rnd());
            t.vld = port_connected & port_active;
            t.cmp = t.vld;
            t.byt = push_byte;
            t.spd = {3{clamp(s, 1'b0)}};
            txq.push_back(t);
        end
        @(negedge sys_clk);
        push = 1'b0;
        wait_empty();
    endtask
    task automatic rx_byte(input int p, input speed_type s, input bit drop);
        note_type t;
        logic [7:0] b;
        logic [3:0] w;
        logic [2:0] bil;
        b = 8'(rnd());
        w = width(s);
        bil = ~port_force_legacy & port_peer_bilingual & port_connected;
        t.vld = port_connected & port_active & ~(3'b001 << p);
        t.cmp = t.vld & ~bil;
        t.byt = b;
        for (int i = 0; i < 3; i++) t.spd[3*i+:3] = clamp(s, bil[i]);
        if (t.vld != 3'b000) txq.push_back(t);
        for (int i = 0; i < 8 / w && !drop; i++)
            rxq.push_back({8'hff >> (8 - w), 8'(b >> (8 - w * (i + 1))) & (8'hff >> (8 - w))});
        @(negedge sys_clk);
        cable_rx_byte[8*p+:8] = b;
        cable_rx_speed[3*p+:3] = s;
        cable_rx_valid[p] = 1'b1;
        @(negedge sys_clk);
        cable_rx_valid = 3'b000;
        cable_rx_byte = ~cable_rx_byte;
    endtask
    task automatic power_down();
        int bad;
        bad = 0;
        @(negedge sys_clk);
        pll_power_down_input = 1'b1;
        repeat (2) @(negedge sys_clk);
        repeat (60) begin
            @(negedge sys_clk);
            if (link_clk_out !== 1'b0 || pll_running !== 1'b0) bad++;
        end
        check(bad == 0, "pll stopped");
        pll_power_down_input = 1'b0;
        repeat (3) @(negedge sys_clk);
        check(pll_running === 1'b1, "pll restarted");
    endtask

    initial begin
        {sys_clk, rst, link_protocol_select, pll_power_down_input, push} = 5'b01000;
        {port_connected, port_active, port_force_legacy, port_peer_bilingual} = 12'h000;
        {cable_rx_byte, cable_rx_valid, cable_rx_speed} = 36'h0;
        link_tx_speed = SPD_S100;
        push_byte = 8'h00;
        chunk_w = 4'h2;
        seed = 32'h31;
        {mismatches, tests_run, cycles} = 0;
        rst_mode(1'b0);
        clk_rate(49152);
        ports(3'b101, 3'b111, 3'b000, 3'b000);
        for (int i = 0; i < 3; i++) tx_bytes(speed_type'(i), 3);
        test_done("legacy transmit");
        ports(3'b111, 3'b111, 3'b010, 3'b110);
        for (int i = 0; i < 3; i++) begin
            rx_byte(i, speed_type'(i), 0);
            wait_empty();
        end
        check(link_rx_overrun === 1'b0, "no overrun");
        rx_byte(0, SPD_S100, 0);
        rx_byte(1, SPD_S100, 0);
        rx_byte(2, SPD_S100, 1);
        wait_empty();
        check(link_rx_overrun === 1'b1, "overrun flagged");
        test_done("legacy receive");
        power_down();
        test_done("power down");
        rst_mode(1'b1);
        clk_rate(98304);
        ports(3'b111, 3'b111, 3'b000, 3'b000);
        tx_bytes(SPD_S800, 4);
        ports(3'b111, 3'b011, 3'b000, 3'b111);
        rx_byte(1, SPD_S800, 0);
        rx_byte(0, SPD_S400B, 0);
        wait_empty();
        ports(3'b111, 3'b111, 3'b111, 3'b111);
        rx_byte(2, SPD_S800, 0);
        wait_empty();
        test_done("newer mode");
        end_of_test();
    end
endmodule
`default_nettype wire
